// ==== rtl/esb_pkg.sv ====
package esb_pkg;

    // ----------------------------------------
    // Bus modes and widths
    // ----------------------------------------
    localparam logic [1:0] MODE_16_MUX = 2'h0;
    localparam logic [1:0] MODE_8_MUX = 2'h1;
    localparam logic [1:0] MODE_8_NONMUX = 2'h2;
    localparam int WAIT_W = 4;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REGIONS = 4;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int PAGE_LSB = 2;
    localparam logic [REGIONS-1:0] SELECT_IDLE = 4'hf;
    localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;

    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_HOLD,
        ST_STROBE,
        ST_RECOV
    } esb_state_t;

endpackage

// ==== rtl/esb_tmr_if.sv ====
`timescale 1ns/1ps
interface esb_tmr_if;
    import esb_pkg::*;
    logic load;
    logic [WAIT_W-1:0] count;
    logic done;

    modport seq (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface

// ==== rtl/esb_wait_timer.sv ====
`timescale 1ns/1ps
module esb_wait_timer
    import esb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Sequencer side
    esb_tmr_if.timer tmr
);

    logic [WAIT_W-1:0] count_q;

    // Strobe ends when the wait count is used up
    assign tmr.done = (count_q == WAIT_RESET);

    // Load on strobe entry, then count down
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_q <= WAIT_RESET;
        end else if (tmr.load) begin
            count_q <= tmr.count;
        end else if (!tmr.done) begin
            count_q <= count_q - 4'h1;
        end
    end

endmodule

// ==== rtl/esb_top.sv ====
`timescale 1ns/1ps
module esb_top
    import esb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_ale_high,
    input wire logic cfg_page_en,
    input wire logic [REGIONS*WAIT_W-1:0] cfg_read_waits,
    input wire logic [REGIONS*WAIT_W-1:0] cfg_write_waits,
    // Request from the on-chip master
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_region,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_byte_en,
    // Answer to the master
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Strobes and selects
    output logic region0_select_n,
    output logic region1_select_n,
    output logic region2_select_n,
    output logic region3_select_n,
    output logic address_latch_strobe,
    output logic low_byte_write_strobe_n,
    output logic high_byte_write_strobe_n,
    output logic read_strobe_n,
    output logic byte_write_strobe_n,
    // Port pins
    output logic [7:0] port7_out,
    input wire logic [7:0] port8_in,
    output logic [7:0] port8_out,
    output logic port8_oe,
    input wire logic [7:0] port9_in,
    output logic [7:0] port9_out,
    output logic port9_oe
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [WAIT_W-1:0] pick_waits(
        input logic [REGIONS*WAIT_W-1:0] vec,
        input logic [1:0] region
    );
        pick_waits = vec[region*WAIT_W +: WAIT_W];
    endfunction

    // ----------------------------------------
    // State and latched request
    // ----------------------------------------
    esb_state_t state_q, state_d;
    logic wr_q, wr_d;
    logic last_rd_q, last_rd_d;
    logic [1:0] region_q, region_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [1:0] be_q, be_d;
    logic [7:0] p8_meta_q, p8_sync_q, p9_meta_q, p9_sync_q;
    logic rsp_valid_q;
    logic [DATA_W-1:0] rsp_rdata_q, rsp_rdata_d;
    logic [REGIONS-1:0] select_n_q, select_n_d;
    logic ale_q, ale_d;
    logic wrl_n_q, wrl_n_d, wrh_n_q, wrh_n_d;
    logic rd_n_q, rd_n_d, bwl_n_q, bwl_n_d;
    logic [7:0] p7_q, p7_d, p8_q, p8_d, p9_q, p9_d;
    logic p8_oe_q, p8_oe_d, p9_oe_q, p9_oe_d;

    esb_tmr_if tmr ();

    esb_wait_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tmr(tmr)
    );

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    wire is_mux = !cfg_mode[1]; // Codes 2 and 3 both non-mux
    wire is_16 = (cfg_mode == MODE_16_MUX);
    wire is_8mux = (cfg_mode == MODE_8_MUX);
    wire accept = req_valid && (state_q == ST_IDLE);
    wire page_hit = cfg_page_en && !is_mux && !req_write && last_rd_q
        && (req_region == region_q)
        && (req_addr[15:PAGE_LSB] == addr_q[15:PAGE_LSB]);
    wire strobe_end = (state_q == ST_STROBE) && tmr.done;

    // One access at a time: ready only while idle
    assign req_ready = (state_q == ST_IDLE);

    // Latch request on acceptance
    assign wr_d = accept ? req_write : wr_q;
    assign region_d = accept ? req_region : region_q;
    assign addr_d = accept ? req_addr : addr_q;
    assign wdata_d = accept ? req_wdata : wdata_q;
    assign be_d = accept ? req_byte_en : be_q;
    assign last_rd_d = strobe_end ? !wr_q : (accept ? 1'b0 : last_rd_q);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Address phase (skipped on a page hit), latch hold (mux only), strobe, recovery
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_d = page_hit ? ST_STROBE : ST_ADDR;
                end
            end
            ST_ADDR: begin
                state_d = is_mux ? ST_HOLD : ST_STROBE;
            end
            ST_HOLD: begin
                state_d = ST_STROBE;
            end
            ST_STROBE: begin
                if (tmr.done) begin
                    state_d = ST_RECOV;
                end
            end
            ST_RECOV: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Wait count per region and direction, loaded on strobe entry
    assign tmr.load = (state_d == ST_STROBE) && (state_q != ST_STROBE);
    assign tmr.count = wr_d ? pick_waits(cfg_write_waits, region_d)
        : pick_waits(cfg_read_waits, region_d);

    // ----------------------------------------
    // Pin values from the next state
    // ----------------------------------------
    wire cs_on = (state_d == ST_ADDR) || (state_d == ST_HOLD)
        || (state_d == ST_STROBE);
    wire ale_on = is_mux && (state_d == ST_ADDR);
    wire adr_ph = is_mux && ((state_d == ST_ADDR) || (state_d == ST_HOLD));
    wire strb = (state_d == ST_STROBE);
    wire dat_ph = strb || (state_d == ST_RECOV);

    // Region select decode
    assign select_n_d = cs_on ? ~(4'h1 << region_d) : SELECT_IDLE;
    // Latch strobe with programmable polarity
    assign ale_d = cfg_ale_high ? ale_on : !ale_on;
    // Strobes per mode
    assign rd_n_d = !(strb && !wr_d);
    assign wrl_n_d = !(strb && wr_d && (is_8mux || (is_16 && be_d[0])));
    assign wrh_n_d = !(strb && wr_d && is_16 && be_d[1]);
    assign bwl_n_d = !(strb && wr_d && !is_mux);

    // Port 7: top address in mux modes, high half in non-mux
    assign p7_d = is_mux ? addr_d[23:16] : addr_d[15:8];

    // Port 8: low address then data, or data only in non-mux
    assign p8_d = adr_ph ? addr_d[7:0] : wdata_d[7:0];
    assign p8_oe_d = adr_ph || (dat_ph && wr_d);

    // Port 9: middle address, then high data or zeros; low address in non-mux
    always_comb begin
        p9_d = 8'h00;
        p9_oe_d = 1'b0;
        if (!is_mux) begin
            p9_d = addr_d[7:0];
            p9_oe_d = cs_on || (state_d == ST_RECOV);
        end else if (adr_ph) begin
            p9_d = addr_d[15:8];
            p9_oe_d = 1'b1;
        end else if (dat_ph && wr_d) begin
            p9_d = is_16 ? wdata_d[15:8] : 8'h00;
            p9_oe_d = 1'b1;
        end
    end

    // Read data capture; port 9 ignored outside 16-bit mode
    assign rsp_rdata_d = (strobe_end && !wr_q)
        ? {(is_16 ? p9_sync_q : 8'h00), p8_sync_q} : rsp_rdata_q;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Input synchronisers
    always_ff @(posedge sys_clk) begin
        p8_meta_q <= port8_in;
        p8_sync_q <= p8_meta_q;
        p9_meta_q <= port9_in;
        p9_sync_q <= p9_meta_q;
    end

    // Sequencer and request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            wr_q <= 1'b0;
            last_rd_q <= 1'b0;
            region_q <= 2'h0;
            addr_q <= 24'h000000;
            wdata_q <= 16'h0000;
            be_q <= 2'h0;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            wr_q <= wr_d;
            last_rd_q <= last_rd_d;
            region_q <= region_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            be_q <= be_d;
            rsp_valid_q <= strobe_end;
            rsp_rdata_q <= rsp_rdata_d;
        end
    end

    // Pin flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            select_n_q <= SELECT_IDLE;
            ale_q <= 1'b0;
            rd_n_q <= 1'b1;
            wrl_n_q <= 1'b1;
            wrh_n_q <= 1'b1;
            bwl_n_q <= 1'b1;
            p7_q <= 8'h00;
            p8_q <= 8'h00;
            p9_q <= 8'h00;
            p8_oe_q <= 1'b0;
            p9_oe_q <= 1'b0;
        end else begin
            select_n_q <= select_n_d;
            ale_q <= ale_d;
            rd_n_q <= rd_n_d;
            wrl_n_q <= wrl_n_d;
            wrh_n_q <= wrh_n_d;
            bwl_n_q <= bwl_n_d;
            p7_q <= p7_d;
            p8_q <= p8_d;
            p9_q <= p9_d;
            p8_oe_q <= p8_oe_d;
            p9_oe_q <= p9_oe_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign region0_select_n = select_n_q[0];
    assign region1_select_n = select_n_q[1];
    assign region2_select_n = select_n_q[2];
    assign region3_select_n = select_n_q[3];
    assign address_latch_strobe = ale_q;
    assign low_byte_write_strobe_n = wrl_n_q;
    assign high_byte_write_strobe_n = wrh_n_q;
    assign read_strobe_n = rd_n_q;
    assign byte_write_strobe_n = bwl_n_q;
    assign port7_out = p7_q;
    assign port8_out = p8_q;
    assign port8_oe = p8_oe_q;
    assign port9_out = p9_q;
    assign port9_oe = p9_oe_q;

endmodule

// ==== testbench/esb_asserts.sv ====
`timescale 1ns/1ps
module esb_asserts
    import esb_pkg::*;
(
    // Clock, reset and configuration
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_ale_high,
    // Watched outputs
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic region0_select_n,
    input wire logic region1_select_n,
    input wire logic region2_select_n,
    input wire logic region3_select_n,
    input wire logic address_latch_strobe,
    input wire logic low_byte_write_strobe_n,
    input wire logic high_byte_write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic byte_write_strobe_n,
    input wire logic [7:0] port9_out,
    input wire logic port8_oe,
    input wire logic port9_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Helper signals
    // ----------------------------------------
    logic [3:0] sel_n;
    logic strb_n;
    assign sel_n = {region3_select_n, region2_select_n, region1_select_n,
                    region0_select_n};
    assign strb_n = read_strobe_n & low_byte_write_strobe_n
                    & high_byte_write_strobe_n & byte_write_strobe_n;

    sequence s_ale_on;
        $changed(address_latch_strobe) && address_latch_strobe == cfg_ale_high;
    endsequence
    sequence s_strobe_end;
        $rose(strb_n);
    endsequence

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_one_region: assert property ($onehot0(~sel_n))
        else $error("more than one region selected");
    a_idle_no_select: assert property (req_ready |-> sel_n == 4'hf)
        else $error("select active while idle");
    a_strobe_in_select: assert property (!strb_n |-> sel_n != 4'hf)
        else $error("strobe without select");
    a_strobe_end_done: assert property (s_strobe_end |-> rsp_valid)
        else $error("strobe end without answer");
    a_read_released: assert property (!read_strobe_n |-> !port8_oe)
        else $error("data pins driven during read");
    a_write_driven: assert property (
        !(low_byte_write_strobe_n & byte_write_strobe_n) |-> port8_oe)
        else $error("data pins released during write");
    a_port9_zero: assert property ((cfg_mode == MODE_8_MUX
        && !low_byte_write_strobe_n) |-> port9_oe && port9_out == 8'h00)
        else $error("port 9 not zero in write data phase");
    a_no_high_strobe: assert property (
        cfg_mode != MODE_16_MUX |-> high_byte_write_strobe_n)
        else $error("high byte strobe in eight bit mode");
    a_no_byte_strobe: assert property ((cfg_mode == MODE_16_MUX
        || cfg_mode == MODE_8_MUX) |-> byte_write_strobe_n)
        else $error("byte strobe in multiplexed mode");
    a_nonmux_no_ale: assert property ((cfg_mode == MODE_8_NONMUX
        && sel_n != 4'hf) |-> address_latch_strobe != cfg_ale_high)
        else $error("latch strobe in non multiplexed mode");
    a_ale_pulse: assert property (s_ale_on |-> sel_n != 4'hf
        ##1 address_latch_strobe != cfg_ale_high)
        else $error("latch strobe malformed");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
endmodule

bind esb_top esb_asserts u_chk (.sys_clk, .rst_n, .cfg_mode, .cfg_ale_high,
    .req_ready, .rsp_valid, .region0_select_n, .region1_select_n,
    .region2_select_n, .region3_select_n, .address_latch_strobe,
    .low_byte_write_strobe_n, .high_byte_write_strobe_n, .read_strobe_n,
    .byte_write_strobe_n, .port9_out, .port8_oe, .port9_oe);

// ==== testbench/esb_mem_model.sv ====
`timescale 1ns/1ps
module esb_mem_model
    import esb_pkg::*;
(
    // Clock, mode and latch strobe
    input wire logic sys_clk,
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_ale_high,
    input wire logic address_latch_strobe,
    // Strobes
    input wire logic read_strobe_n,
    input wire logic low_byte_write_strobe_n,
    input wire logic high_byte_write_strobe_n,
    input wire logic byte_write_strobe_n,
    // Pins
    input wire logic [7:0] port7_out,
    input wire logic [7:0] port8_out,
    input wire logic [7:0] port9_out,
    input wire logic port8_oe,
    input wire logic port9_oe,
    output logic [7:0] port8_in,
    output logic [7:0] port9_in
);
    logic [7:0] lo [256];
    logic [7:0] hi [256];
    logic [23:0] lat_q = 24'h0;
    logic [7:0] idle_q = 8'h5a;
    logic [23:0] a;
    logic [7:0] ix;
    // Address: latched in mux modes, direct otherwise
    assign a = cfg_mode[1] ? {8'h00, port7_out, port9_out} : lat_q;
    assign ix = a[7:0] ^ a[15:8] ^ a[23:16];
    // Latch, byte writes and changing idle pattern
    always @(posedge sys_clk) begin
        idle_q <= ~idle_q;
        if (address_latch_strobe == cfg_ale_high)
            lat_q <= {port7_out, port9_out, port8_out};
        if (!(low_byte_write_strobe_n & byte_write_strobe_n))
            lo[ix] <= port8_out;
        if (!high_byte_write_strobe_n)
            hi[ix] <= port9_out;
    end
    // Pin level from both parties, no pull-ups on the pins
    assign port8_in = port8_oe ? port8_out : !read_strobe_n ? lo[ix] : idle_q;
    assign port9_in = port9_oe ? port9_out
        : (!read_strobe_n && cfg_mode == MODE_16_MUX) ? hi[ix] : ~idle_q;
endmodule

// ==== testbench/external_static_memory_bus_tb.sv ====
`timescale 1ns/1ps
module external_static_memory_bus_tb;
    import esb_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] cfg_mode = MODE_16_MUX;
    logic cfg_ale_high = 1'b0;
    logic cfg_page_en = 1'b0;
    logic [15:0] cfg_read_waits = 16'h5432;
    logic [15:0] cfg_write_waits = 16'h3210;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_region = 2'h0;
    logic [23:0] req_addr = 24'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [1:0] req_byte_en = 2'h3;
    logic req_ready, rsp_valid, address_latch_strobe, read_strobe_n;
    logic low_byte_write_strobe_n, high_byte_write_strobe_n;
    logic byte_write_strobe_n, port8_oe, port9_oe, region0_select_n;
    logic region1_select_n, region2_select_n, region3_select_n;
    logic [15:0] rsp_rdata, rd, wd;
    logic [7:0] port7_out, port8_out, port8_in, port9_out, port9_in;
    logic [23:0] ad;
    logic pg = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    esb_top DUT (.*);
    esb_mem_model MEM (.*);

    always #12.5 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access: request at falling edge, watch pins until answer
    task automatic access(input logic wr, input logic [1:0] rg,
            input logic [1:0] be);
        int n;
        int k;
        int w;
        logic [3:0] seen;
        n = 0;
        k = 0;
        w = int'(wr ? cfg_write_waits[4*rg +: 4]
                    : cfg_read_waits[4*rg +: 4]);
        seen = 4'hf;
        while (!req_ready) @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_region = rg;
        req_addr = ad;
        req_wdata = wd;
        req_byte_en = be;
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (int i = 0; i < 64; i++) begin
            seen &= {region3_select_n, region2_select_n, region1_select_n,
                     region0_select_n};
            if (!(read_strobe_n & low_byte_write_strobe_n
                  & high_byte_write_strobe_n & byte_write_strobe_n))
                n++;
            if (rsp_valid)
                break;
            k++;
            @(negedge sys_clk);
        end
        rd = rsp_rdata;
        check("answer", 16'h1, {15'h0, rsp_valid});
        check("strobe cycles", 16'(n), 16'h1 + 16'(wr ?
            cfg_write_waits[4*rg +: 4] : cfg_read_waits[4*rg +: 4]));
        check("select", {12'h0, ~(4'h1 << rg)}, {12'h0, seen});
        // Cycles from take to answer: hold cycle only when multiplexed
        check("latency", 16'(k),
            16'(w + (cfg_mode[1] ? 2 : 3) - (pg ? 1 : 0)));
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        // Every mode and region, write then read back
        for (int m = 0; m < 3; m++) begin
            cfg_mode = 2'(m);
            cfg_ale_high = m[0];
            for (int r = 0; r < 4; r++) begin
                ad = {8'(8'h31 * r + m), 8'(8'h17 + r), 8'(8'h40 + 4 * m)};
                wd = 16'ha5c0 + 16'(m * 16 + r * 3);
                access(1'b1, 2'(r), 2'h3);
                access(1'b0, 2'(r), 2'h3);
                check("read data", m == 0 ? wd : {8'h00, wd[7:0]}, rd);
            end
        end
        // Byte enables in 16-bit mux, back to back
        cfg_mode = MODE_16_MUX;
        ad = 24'h7e0c12;
        wd = 16'h1234;
        access(1'b1, 2'h2, 2'h3);
        wd = 16'habcd;
        access(1'b1, 2'h2, 2'h1);
        access(1'b0, 2'h2, 2'h3);
        check("byte masked data", 16'h12cd, rd);
        // Page reads in non-mux mode
        cfg_mode = MODE_8_NONMUX;
        cfg_page_en = 1'b1;
        ad = 24'h00c8a4;
        wd = 16'h0066;
        access(1'b1, 2'h3, 2'h3);
        ad = 24'h00c8a5;
        wd = 16'h0099;
        access(1'b1, 2'h3, 2'h3);
        ad = 24'h00c8a4;
        access(1'b0, 2'h3, 2'h3);
        check("page read first", 16'h0066, rd);
        ad = 24'h00c8a5;
        pg = 1'b1;
        access(1'b0, 2'h3, 2'h3);
        pg = 1'b0;
        check("page read second", 16'h0099, rd);
        // Page mode refused while multiplexed
        cfg_mode = MODE_16_MUX;
        ad = 24'h7e0c12;
        access(1'b0, 2'h2, 2'h3);
        access(1'b0, 2'h2, 2'h3);
        check("mux read no page", 16'h12cd, rd);
        stop_test();
    end
endmodule
